// ### logic/mic_cfg.svh
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH

// sizes
`define MIC_NSRC       12
`define MIC_IDX_W      4
`define MIC_VEC_W      16
`define MIC_DATA_W     32
`define MIC_ADDR_W     4
`define MIC_NEV        4

// register addresses
`define MIC_REG_CTRL   4'h0
`define MIC_REG_STAT   4'h1
`define MIC_REG_CFG    4'h2
`define MIC_REG_PEND   4'h3
`define MIC_REG_EV     4'h4
`define MIC_REG_MASK   4'h5
`define MIC_REG_LAST   4'h6

// control fields and register reset values
`define MIC_CTRL_W     5
`define MIC_CTRL_RR    0
`define MIC_CTRL_IVSEL 1
`define MIC_CTRL_LOEN  2
`define MIC_CTRL_RST   5'h00
`define MIC_CFG_RST    24'h00_0000
`define MIC_EV_RST     4'h0
`define MIC_MASK_RST   4'h0

// event and active bit positions
`define MIC_B_LO       0
`define MIC_B_MED      1
`define MIC_B_HI       2
`define MIC_B_NMI      3

// level codes
`define MIC_LVL_OFF    2'h0
`define MIC_LVL_LO     2'h1
`define MIC_LVL_MED    2'h2
`define MIC_LVL_HI     2'h3

// vector word addresses, table step and boot table offset
`define MIC_VEC_RESET  16'h0000
`define MIC_VEC_OSCF   16'h0002
`define MIC_VEC_PORTC  16'h0004
`define MIC_VEC_PORTR  16'h0008
`define MIC_VEC_DMA    16'h000C
`define MIC_VEC_RTC    16'h0014
`define MIC_VEC_TWIC   16'h0018
`define MIC_VEC_STEP   16'h0002
`define MIC_VEC_BOOT   16'hF000
`endif

// ### logic/mic_pkg.sv
`include "mic_cfg.svh"
package mic_pkg;
   typedef logic [`MIC_VEC_W-1:0] mic_vec_t;

   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic [`MIC_ADDR_W-1:0] addr;
      logic [`MIC_DATA_W-1:0] wdata;
   } mic_reg_req_t;

   typedef struct packed {
      logic                  valid;
      logic                  nmi;
      logic [1:0]            level;
      logic [`MIC_IDX_W-1:0] idx;
      mic_vec_t              vector;
   } mic_grant_t;

   typedef enum logic {MIC_ST_BOOT, MIC_ST_RUN} mic_state_t;
endpackage : mic_pkg

// ### logic/mic_pick.sv
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_pick
   import mic_pkg::*;
(
   // requests and search start
   input  wire logic [`MIC_NSRC-1:0]  req_in,
   input  wire logic [`MIC_IDX_W-1:0] start_in,
   // result
   output logic                       hit_out,
   output logic [`MIC_IDX_W-1:0]      idx_out
);
   // scan downward so the first index at or after start_in is the last to win
   always_comb begin : scan
      int unsigned k;
      k       = 0;
      hit_out = 1'b0;
      idx_out = '0;
      for (int i = `MIC_NSRC - 1; i >= 0; i--) begin
         k = (int'(start_in) + i) % `MIC_NSRC;
         if (req_in[k]) begin
            hit_out = 1'b1;
            idx_out = `MIC_IDX_W'(k);
         end
      end
   end
endmodule : mic_pick

// ### logic/mic_multilevel_irq_ctrl.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_multilevel_irq_ctrl
   import mic_pkg::*;
(
   // clock and reset
   input  wire logic                   sys_clk_in,
   input  wire logic                   reset_in,
   // register port
   input  wire mic_reg_req_t           reg_req_in,
   output logic [`MIC_DATA_W-1:0]      rd_data_out,
   // peripheral requests
   input  wire logic [`MIC_NSRC-1:0]   src_cond_in,
   input  wire logic                   osc_fail_in,
   // processor core
   input  wire logic                   cpu_ack_in,
   input  wire logic                   cpu_reti_in,
   output mic_grant_t                  grant_out,
   output logic                        pc_load_out,
   output mic_vec_t                    pc_value_out,
   // event interrupt
   output logic                        irq_out
);

   mic_state_t                 state_q;
   logic [`MIC_CTRL_W-1:0]     ctrl_q;
   logic [2*`MIC_NSRC-1:0]     cfg_q;
   logic [`MIC_NEV-1:0]        ev_q;
   logic [`MIC_NEV-1:0]        ev_d;
   logic [`MIC_NEV-1:0]        ev_set;
   logic [`MIC_NEV-1:0]        mask_q;
   logic [`MIC_NEV-1:0]        mask_d;
   logic [`MIC_NEV-1:0]        active_q;
   logic [`MIC_NEV-1:0]        active_d;
   logic [`MIC_IDX_W-1:0]      last_lo_q;
   logic [`MIC_IDX_W-1:0]      lo_start;
   logic [`MIC_NSRC-1:0]       pend;
   logic [1:0]                 src_lvl [`MIC_NSRC];
   logic [`MIC_NSRC-1:0]       lvl_req [3];
   logic [2:0]                 lvl_hit;
   logic [`MIC_IDX_W-1:0]      lvl_idx [3];
   logic [`MIC_IDX_W-1:0]      start_sel [3];
   mic_grant_t                 win;
   mic_grant_t                 grant_q;
   logic                       took;
   logic                       wr_ctrl;
   logic                       wr_cfg;
   logic                       wr_ev;
   logic                       wr_mask;
   logic [`MIC_DATA_W-1:0]     rd_d;
   logic [`MIC_DATA_W-1:0]     rd_data_q;
   logic                       pc_load_q;
   mic_vec_t                   pc_value_q;
   logic                       irq_q;

   // helpers

   // peripheral base plus offset inside the peripheral, moved into boot when selected
   function automatic mic_vec_t src_vector(input logic [`MIC_IDX_W-1:0] idx,
                                           input logic                  boot);
      mic_vec_t base;
      mic_vec_t sub;
      base = `MIC_VEC_PORTC;
      sub  = '0;
      unique case (idx)
         4'h0, 4'h1: begin
            base = `MIC_VEC_PORTC;
            sub  = {15'h0000, idx[0]};
         end
         4'h2, 4'h3: begin
            base = `MIC_VEC_PORTR;
            sub  = {15'h0000, idx[0]};
         end
         4'h4, 4'h5, 4'h6, 4'h7: begin
            base = `MIC_VEC_DMA;
            sub  = {14'h0000, idx[1:0]};
         end
         4'h8, 4'h9: begin
            base = `MIC_VEC_RTC;
            sub  = {15'h0000, idx[0]};
         end
         default: begin
            base = `MIC_VEC_TWIC;
            sub  = {15'h0000, idx[0]};
         end
      endcase
      src_vector = table_at(base + `MIC_VEC_W'(sub * `MIC_VEC_STEP), boot);
   endfunction : src_vector

   // table relocation, word addressed throughout
   function automatic mic_vec_t table_at(input mic_vec_t vec, input logic boot);
      table_at = boot ? vec + `MIC_VEC_BOOT : vec;
   endfunction : table_at

   // level code to event/active bit
   function automatic logic [`MIC_NEV-1:0] lvl_bit(input logic [1:0] lvl);
      lvl_bit = '0;
      unique case (lvl)
         `MIC_LVL_LO:  lvl_bit[`MIC_B_LO]  = 1'b1;
         `MIC_LVL_MED: lvl_bit[`MIC_B_MED] = 1'b1;
         `MIC_LVL_HI:  lvl_bit[`MIC_B_HI]  = 1'b1;
         default:      lvl_bit = '0;
      endcase
   endfunction : lvl_bit

   // request gathering

   generate
      for (genvar g = 0; g < `MIC_NSRC; g++) begin : g_src
         assign src_lvl[g] = cfg_q[2*g +: 2];
         assign pend[g]    = src_cond_in[g] && (src_lvl[g] != `MIC_LVL_OFF);
      end
   endgenerate

   // round robin restarts just after the last low source served
   always_comb begin
      lo_start = '0;
      if (ctrl_q[`MIC_CTRL_RR]) begin
         if (last_lo_q == `MIC_IDX_W'(`MIC_NSRC - 1)) begin
            lo_start = '0;
         end else begin
            lo_start = last_lo_q + `MIC_IDX_W'(1);
         end
      end
   end

   generate
      for (genvar l = 0; l < 3; l++) begin : g_lvl
         always_comb begin
            for (int s = 0; s < `MIC_NSRC; s++) begin
               lvl_req[l][s] = pend[s] && (src_lvl[s] == 2'(l + 1));
            end
         end
         assign start_sel[l] = (l == 0) ? lo_start : '0;
         mic_pick u_pick (
            .req_in   (lvl_req[l]),
            .start_in (start_sel[l]),
            .hit_out  (lvl_hit[l]),
            .idx_out  (lvl_idx[l])
         );
      end
   endgenerate

   // arbitration
   // nmi ignores the level enables and is held off only by its own handler

   always_comb begin
      win = '0;
      if (state_q == MIC_ST_RUN && !active_q[`MIC_B_NMI]) begin
         if (osc_fail_in) begin
            win.valid  = 1'b1;
            win.nmi    = 1'b1;
            win.level  = `MIC_LVL_HI;
            win.vector = table_at(`MIC_VEC_OSCF, ctrl_q[`MIC_CTRL_IVSEL]);
         end else if (lvl_hit[2] && ctrl_q[`MIC_CTRL_LOEN + 2]
                      && !active_q[`MIC_B_HI]) begin
            win.valid  = 1'b1;
            win.level  = `MIC_LVL_HI;
            win.idx    = lvl_idx[2];
            win.vector = src_vector(lvl_idx[2], ctrl_q[`MIC_CTRL_IVSEL]);
         end else if (lvl_hit[1] && ctrl_q[`MIC_CTRL_LOEN + 1]
                      && !active_q[`MIC_B_HI] && !active_q[`MIC_B_MED]) begin
            win.valid  = 1'b1;
            win.level  = `MIC_LVL_MED;
            win.idx    = lvl_idx[1];
            win.vector = src_vector(lvl_idx[1], ctrl_q[`MIC_CTRL_IVSEL]);
         end else if (lvl_hit[0] && ctrl_q[`MIC_CTRL_LOEN]
                      && active_q[`MIC_B_HI:`MIC_B_LO] == 3'h0) begin
            win.valid  = 1'b1;
            win.level  = `MIC_LVL_LO;
            win.idx    = lvl_idx[0];
            win.vector = src_vector(lvl_idx[0], ctrl_q[`MIC_CTRL_IVSEL]);
         end
      end
   end

   assign took = cpu_ack_in && grant_q.valid;

   // grant is withdrawn in the acknowledge cycle so a stale copy is never taken twice
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         grant_q <= '0;
      end else if (took) begin
         grant_q <= '0;
      end else begin
         grant_q <= win;
      end
   end

   // startup and vector load
   // one boot cycle issues the reset vector before any grant can form

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_q <= MIC_ST_BOOT;
      end else begin
         unique case (state_q)
            MIC_ST_BOOT: state_q <= MIC_ST_RUN;
            MIC_ST_RUN:  state_q <= MIC_ST_RUN;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pc_load_q  <= 1'b0;
         pc_value_q <= `MIC_VEC_RESET;
      end else if (state_q == MIC_ST_BOOT) begin
         pc_load_q  <= 1'b1;
         pc_value_q <= table_at(`MIC_VEC_RESET, ctrl_q[`MIC_CTRL_IVSEL]);
      end else if (took) begin
         pc_load_q  <= 1'b1;
         pc_value_q <= grant_q.vector;
      end else begin
         pc_load_q  <= 1'b0;
      end
   end

   // active level tracking

   // return retires the most urgent active handler, then a new entry is added
   always_comb begin
      active_d = active_q;
      if (cpu_reti_in) begin
         if (active_q[`MIC_B_NMI]) begin
            active_d[`MIC_B_NMI] = 1'b0;
         end else if (active_q[`MIC_B_HI]) begin
            active_d[`MIC_B_HI] = 1'b0;
         end else if (active_q[`MIC_B_MED]) begin
            active_d[`MIC_B_MED] = 1'b0;
         end else begin
            active_d[`MIC_B_LO] = 1'b0;
         end
      end
      if (took) begin
         active_d = active_d | ev_set;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         active_q <= '0;
      end else begin
         active_q <= active_d;
      end
   end

   // only low grants move the round robin pointer, nmi and upper levels leave it
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         last_lo_q <= '0;
      end else if (took && !grant_q.nmi && grant_q.level == `MIC_LVL_LO) begin
         last_lo_q <= grant_q.idx;
      end
   end

   // register port

   assign wr_ctrl = reg_req_in.wr && reg_req_in.addr == `MIC_REG_CTRL;
   assign wr_cfg  = reg_req_in.wr && reg_req_in.addr == `MIC_REG_CFG;
   assign wr_ev   = reg_req_in.wr && reg_req_in.addr == `MIC_REG_EV;
   assign wr_mask = reg_req_in.wr && reg_req_in.addr == `MIC_REG_MASK;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ctrl_q <= `MIC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_req_in.wdata[`MIC_CTRL_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         cfg_q <= `MIC_CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= reg_req_in.wdata[2*`MIC_NSRC-1:0];
      end
   end

   // events and mask

   always_comb begin
      ev_set = '0;
      if (took) begin
         ev_set = grant_q.nmi ? `MIC_NEV'(1 << `MIC_B_NMI) : lvl_bit(grant_q.level);
      end
      // a new event wins over a write-one clear in the same cycle
      ev_d = ev_q;
      if (wr_ev) begin
         ev_d = ev_q & ~reg_req_in.wdata[`MIC_NEV-1:0];
      end
      ev_d   = ev_d | ev_set;
      mask_d = wr_mask ? reg_req_in.wdata[`MIC_NEV-1:0] : mask_q;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ev_q   <= `MIC_EV_RST;
         mask_q <= `MIC_MASK_RST;
         irq_q  <= 1'b0;
      end else begin
         ev_q   <= ev_d;
         mask_q <= mask_d;
         irq_q  <= |(ev_d & mask_d);
      end
   end

   // read data, valid only in the cycle after the strobe

   always_comb begin
      rd_d = '0;
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            `MIC_REG_CTRL: rd_d = `MIC_DATA_W'(ctrl_q);
            `MIC_REG_STAT: rd_d = `MIC_DATA_W'(active_q);
            `MIC_REG_CFG:  rd_d = `MIC_DATA_W'(cfg_q);
            `MIC_REG_PEND: rd_d = `MIC_DATA_W'(pend);
            `MIC_REG_EV:   rd_d = `MIC_DATA_W'(ev_q);
            `MIC_REG_MASK: rd_d = `MIC_DATA_W'(mask_q);
            `MIC_REG_LAST: rd_d = `MIC_DATA_W'(last_lo_q);
            default:       rd_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= rd_d;
      end
   end

   // outputs

   assign rd_data_out  = rd_data_q;
   assign grant_out    = grant_q;
   assign pc_load_out  = pc_load_q;
   assign pc_value_out = pc_value_q;
   assign irq_out      = irq_q;

endmodule : mic_multilevel_irq_ctrl

// ### test/mic_multilevel_irq_ctrl_asserts.sv
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_multilevel_irq_ctrl_chk
   import mic_pkg::*;
(
   // clock and reset
   input wire logic                 sys_clk_in,
   input wire logic                 reset_in,
   // requests and core side
   input wire logic [`MIC_NSRC-1:0] src_cond_in,
   input wire logic                 osc_fail_in,
   input wire logic                 cpu_ack_in,
   input wire logic                 cpu_reti_in,
   input wire mic_grant_t           grant_out,
   input wire logic                 pc_load_out,
   input wire mic_vec_t             pc_value_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   a_ack_loads_pc: assert property (
      cpu_ack_in && grant_out.valid |=> pc_load_out && pc_value_out == $past(grant_out.vector))
      else $error("pc load does not match grant");
   a_ack_drops_grant: assert property (
      cpu_ack_in && grant_out.valid |=> !grant_out.valid)
      else $error("grant still valid after ack");
   a_pc_value_holds: assert property (
      !pc_load_out |-> $stable(pc_value_out))
      else $error("pc value moved without load");
   a_vector_sum: assert property (
      grant_out.valid && !grant_out.nmi |->
         grant_out.vector[11:0] == 12'h004 + {7'h00, grant_out.idx, 1'b0})
      else $error("vector is not base plus offset");
   a_nmi_vector: assert property (
      grant_out.valid && grant_out.nmi |-> grant_out.vector[11:0] == 12'h002)
      else $error("nmi vector wrong");
   a_nmi_needs_osc: assert property (
      grant_out.valid && grant_out.nmi |-> $past(osc_fail_in))
      else $error("nmi grant without request");
   a_grant_has_cond: assert property (
      grant_out.valid && !grant_out.nmi |->
         ($past(src_cond_in) & (`MIC_NSRC'(1) << grant_out.idx)) != 0)
      else $error("grant without condition");
   a_grant_level_on: assert property (
      grant_out.valid && !grant_out.nmi |-> grant_out.level != `MIC_LVL_OFF)
      else $error("grant for source that is off");
   a_no_equal_preempt: assert property (
      cpu_ack_in && grant_out.valid && !grant_out.nmi ##1 !cpu_reti_in |=>
         !grant_out.valid || grant_out.nmi || grant_out.level > $past(grant_out.level, 2))
      else $error("equal or lower level granted over active handler");
   a_reset_vector: assert property (
      $fell(reset_in) |-> ##[1:3] (pc_load_out && pc_value_out == `MIC_VEC_RESET))
      else $error("no reset vector load");
endmodule : mic_multilevel_irq_ctrl_chk

bind mic_multilevel_irq_ctrl mic_multilevel_irq_ctrl_chk i_mic_multilevel_irq_ctrl_chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .src_cond_in(src_cond_in),
   .osc_fail_in(osc_fail_in), .cpu_ack_in(cpu_ack_in), .cpu_reti_in(cpu_reti_in),
   .grant_out(grant_out),
   .pc_load_out(pc_load_out), .pc_value_out(pc_value_out));

// ### test/mic_core_model.sv
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_core_model
   import mic_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   // controller side
   input  wire mic_grant_t grant_in,
   input  wire logic       pc_load_in,
   input  wire mic_vec_t   pc_value_in,
   output logic            ack_out,
   // bench control and view
   input  wire logic       take_in,
   input  wire logic [3:0] wait_in,
   output mic_vec_t        seen_out,
   output logic [7:0]      loads_out
);
   logic [3:0] cnt_q;

   // ack a valid grant after wait_in cycles, one pulse
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !grant_in.valid || ack_out) begin
         cnt_q   <= 4'h0;
         ack_out <= 1'b0;
      end else begin
         cnt_q   <= cnt_q + 4'h1;
         ack_out <= take_in && (cnt_q == wait_in);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         seen_out  <= 16'hFFFF;
         loads_out <= 8'h00;
      end else if (pc_load_in) begin
         seen_out  <= pc_value_in;
         loads_out <= loads_out + 8'h01;
      end
   end
endmodule : mic_core_model

// ### test/mic_multilevel_irq_ctrl_tb.sv
`timescale 1ns/1ns
`include "mic_cfg.svh"
module mic_multilevel_irq_ctrl_tb;
   import mic_pkg::*;
   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic          osc = 1'b0;
   logic          take = 1'b0;
   logic          ret = 1'b0;
   logic [3:0]    dly = 4'h0;
   logic [11:0]   cond = 12'h000;
   mic_reg_req_t  req = '0;
   logic [31:0]   rdat;
   mic_grant_t    gnt;
   logic          ld;
   logic          irq;
   logic          ack;
   mic_vec_t      pcv;
   mic_vec_t      seen;
   logic [7:0]    loads;
   int            err_total = 0;
   int            compares = 0;
   int            cyc = 0;

   always #10 sys_clk = ~sys_clk;

   mic_multilevel_irq_ctrl i_mic_multilevel_irq_ctrl (
      .sys_clk_in(sys_clk), .reset_in(rst), .reg_req_in(req), .rd_data_out(rdat),
      .src_cond_in(cond), .osc_fail_in(osc), .cpu_ack_in(ack), .cpu_reti_in(ret),
      .grant_out(gnt), .pc_load_out(ld), .pc_value_out(pcv), .irq_out(irq));

   mic_core_model i_mic_core_model (
      .sys_clk_in(sys_clk), .reset_in(rst), .grant_in(gnt), .pc_load_in(ld),
      .pc_value_in(pcv), .ack_out(ack), .take_in(take), .wait_in(dly),
      .seen_out(seen), .loads_out(loads));

   task summarize;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end

   task chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task reg_wr(logic [3:0] a, logic [31:0] d);
      @(posedge sys_clk);
      req <= {2'b10, a, d};
      @(posedge sys_clk);
      req <= '0;
   endtask : reg_wr

   task reg_rd(logic [3:0] a, logic [31:0] e);
      @(posedge sys_clk);
      req <= {2'b01, a, 32'h0000_0000};
      @(posedge sys_clk);
      req <= '0;
      #1 chk($sformatf("reg %h", a), e, rdat);
   endtask : reg_rd

   task sc(logic [11:0] v);
      @(posedge sys_clk);
      cond <= v;
   endtask : sc

   task rt;
      @(posedge sys_clk);
      ret <= 1'b1;
      @(posedge sys_clk);
      ret <= 1'b0;
   endtask : rt

   // wait for the next program counter load and compare it
   task pc_ld(mic_vec_t e);
      int n;
      n = loads;
      repeat (30) if (loads == n) begin
         @(posedge sys_clk);
         #1;
      end
      chk("loads", n + 1, loads);
      chk("pc", e, seen);
   endtask : pc_ld

   task quiet;
      int n;
      n = loads;
      repeat (8) @(posedge sys_clk);
      #1 chk("loads", n, loads);
   endtask : quiet

   task t_regs;
      chk("pc", `MIC_VEC_RESET, seen);
      reg_rd(`MIC_REG_CTRL, 32'h0000_0000);
      reg_rd(`MIC_REG_CFG, 32'h0000_0000);
      reg_rd(`MIC_REG_EV, 32'h0000_0000);
      reg_rd(`MIC_REG_MASK, 32'h0000_0000);
      reg_wr(4'hF, 32'hFFFF_FFFF);
      reg_rd(4'hF, 32'h0000_0000);
      reg_wr(`MIC_REG_STAT, 32'h0000_000F);
      reg_rd(`MIC_REG_STAT, 32'h0000_0000);
   endtask : t_regs

   task t_levels;
      reg_wr(`MIC_REG_CFG, 32'h00CC_0205);
      reg_wr(`MIC_REG_CTRL, 32'h0000_001C);
      sc(12'h017);
      pc_ld(16'h000C);
      quiet();
      reg_rd(`MIC_REG_PEND, 32'h0000_0013);
      sc(12'h217);
      pc_ld(16'h0016);
      reg_rd(`MIC_REG_STAT, 32'h0000_0006);
      sc(12'h003);
      rt();
      quiet();
      rt();
      pc_ld(16'h0004);
      sc(12'h013);
      pc_ld(16'h000C);
      @(posedge sys_clk);
      osc <= 1'b1;
      pc_ld(`MIC_VEC_OSCF);
      reg_rd(`MIC_REG_STAT, 32'h0000_000B);
      @(posedge sys_clk);
      osc <= 1'b0;
      sc(12'h000);
      rt();
      rt();
      rt();
      reg_rd(`MIC_REG_STAT, 32'h0000_0000);
   endtask : t_levels

   task t_irq;
      reg_rd(`MIC_REG_EV, 32'h0000_000F);
      @(posedge sys_clk);
      #1 chk("rdat idle", 32'h0000_0000, rdat);
      chk("irq", 1'b0, irq);
      reg_wr(`MIC_REG_MASK, 32'h0000_0002);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", 1'b1, irq);
      reg_wr(`MIC_REG_EV, 32'h0000_0002);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", 1'b0, irq);
      reg_rd(`MIC_REG_EV, 32'h0000_000D);
      reg_wr(`MIC_REG_EV, 32'h0000_000F);
      reg_wr(`MIC_REG_MASK, 32'h0000_0000);
   endtask : t_irq

   task t_rr;
      reg_rd(`MIC_REG_LAST, 32'h0000_0000);
      reg_wr(`MIC_REG_CTRL, 32'h0000_001D);
      dly <= 4'h3;
      sc(12'h003);
      pc_ld(16'h0006);
      rt();
      pc_ld(16'h0004);
      reg_rd(`MIC_REG_LAST, 32'h0000_0000);
      sc(12'h000);
      rt();
   endtask : t_rr

   task t_boot;
      reg_wr(`MIC_REG_CTRL, 32'h0000_001E);
      sc(12'h200);
      pc_ld(16'hF016);
      sc(12'h000);
      rt();
      reg_wr(`MIC_REG_CTRL, 32'h0000_000E);
      sc(12'h200);
      quiet();
      sc(12'h000);
   endtask : t_boot

   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      take <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_levels();
      t_irq();
      t_rr();
      t_boot();
      summarize();
   end
endmodule : mic_multilevel_irq_ctrl_tb
